// ### smm_defines.svh
// Constants of the per-socket mode register bank: addresses, fields, codes.
// Assumes byte addressing on a 24-bit AXI4-Lite bus with 32-bit data.
`ifndef SMM_DEFINES_SVH
`define SMM_DEFINES_SVH

`define SMM_NUM_SOCK      8
`define SMM_SOCK_BASE     24'hfe4000
`define SMM_SOCK_SHIFT    8
`define SMM_HIT_LSB       11
`define SMM_OFF_MODE      8'h00
`define SMM_OFF_CMD       8'h04
`define SMM_OFF_STAT      8'h08

`define SMM_MODE_RST      8'h00
`define SMM_MODE_WMASK    8'haf
`define SMM_BIT_MULTI     7
`define SMM_BIT_ACKSEL    5
`define SMM_PROTO_MSB     3

`define SMM_PROTO_CLOSED  4'h0
`define SMM_PROTO_TCP     4'h1
`define SMM_PROTO_UDP     4'h2
`define SMM_PROTO_IPRAW   4'h3
`define SMM_PROTO_MACRAW  4'h4
`define SMM_PROTO_PPPOE   4'h5

`define SMM_CMD_OPEN      8'h01
`define SMM_CMD_LISTEN    8'h02
`define SMM_CMD_CONNECT   8'h04
`define SMM_CMD_CLOSE     8'h10

`define SMM_ST_CLOSED     8'h00
`define SMM_ST_INIT       8'h01
`define SMM_ST_LISTEN     8'h02
`define SMM_ST_SYNSENT    8'h03
`define SMM_ST_UDP        8'h04
`define SMM_ST_IPRAW      8'h05
`define SMM_ST_MACRAW     8'h06
`define SMM_ST_PPPOE      8'h07

`define SMM_RESP_OKAY     2'b00
`define SMM_RESP_SLVERR   2'b10

`endif

// ### smm_mode_decode.sv
// Combinational meaning of one socket's mode byte.
// Assumes the mode byte already has its reserved bits cleared.
`timescale 1ns/1ps
`include "smm_defines.svh"
module smm_mode_decode
	import smm_pkg::*;
(
	input  wire logic [7:0] mode,        // Stored mode byte
	input  wire logic       sock_zero,   // This is socket zero
	output logic            is_tcp,      // TCP selected
	output logic            is_udp,      // UDP selected
	output logic            is_mac_raw,  // MAC raw, honoured
	output logic            is_pppoe,    // PPPoE, honoured
	output logic            mcast_on,    // Multicast in force
	output logic            no_dly_ack,  // Immediate ACK in force
	output logic            igmp_v1,     // IGMP version 1 in force
	output logic [7:0]      open_stat    // Status an open would give
);
	logic [3:0] proto;  // Protocol field

	// Protocol field and the options it qualifies
	always_comb begin
		proto      = mode[`SMM_PROTO_MSB:0];
		is_tcp     = (proto == `SMM_PROTO_TCP);
		is_udp     = (proto == `SMM_PROTO_UDP);
		// MAC raw and PPPoE on other sockets behave as closed, never half-open
		is_mac_raw = (proto == `SMM_PROTO_MACRAW) && sock_zero;
		is_pppoe   = (proto == `SMM_PROTO_PPPOE) && sock_zero;
		mcast_on   = mode[`SMM_BIT_MULTI] && is_udp;
		no_dly_ack = mode[`SMM_BIT_ACKSEL] && is_tcp;
		igmp_v1    = mode[`SMM_BIT_ACKSEL] && mcast_on;
		// Status reached by an open command
		if (is_tcp) begin
			open_stat = `SMM_ST_INIT;
		end else if (is_udp) begin
			open_stat = `SMM_ST_UDP;
		end else if (proto == `SMM_PROTO_IPRAW) begin
			open_stat = `SMM_ST_IPRAW;
		end else if (is_mac_raw) begin
			open_stat = `SMM_ST_MACRAW;
		end else if (is_pppoe) begin
			open_stat = `SMM_ST_PPPOE;
		end else begin
			open_stat = `SMM_ST_CLOSED;
		end
	end
endmodule

// ### smm_pkg.sv
// Types and the shared address decoder of the socket mode bank.
// Assumes smm_defines.svh is on the include path.
package smm_pkg;
	`include "smm_defines.svh"

	// Which register of a socket an address hits
	typedef enum logic [1:0] {
		smm_reg_mode,
		smm_reg_cmd,
		smm_reg_stat,
		smm_reg_none
	} smm_reg_t;

	// Result of decoding one bus address
	typedef struct packed {
		logic     hit;
		logic [2:0] sock;
		smm_reg_t kind;
	} smm_dec_t;

	// Split an address into socket and register, flag unmapped ones
	function automatic smm_dec_t smm_decode(input logic [23:0] addr);
		smm_dec_t    r;
		logic [23:0] base;
		base   = `SMM_SOCK_BASE;
		r.sock = addr[`SMM_SOCK_SHIFT+2:`SMM_SOCK_SHIFT];
		unique case (addr[7:0])
			`SMM_OFF_MODE: r.kind = smm_reg_mode;
			`SMM_OFF_CMD:  r.kind = smm_reg_cmd;
			`SMM_OFF_STAT: r.kind = smm_reg_stat;
			default:       r.kind = smm_reg_none;
		endcase
		r.hit = (addr[23:`SMM_HIT_LSB] == base[23:`SMM_HIT_LSB]) && (r.kind != smm_reg_none);
		return r;
	endfunction
endpackage

// ### smm_testbench.sv
// Self-checking bench of the socket mode bank, driven over AXI4-Lite.
// Assumes smm_pkg is compiled first and smm_defines.svh is on the include path.
`timescale 1ns/1ps
`include "smm_defines.svh"
module testbench;
	import smm_pkg::*;
	logic        clk;      // 125 MHz bench clock
	logic        rst;      // Synchronous reset
	logic [23:0] awaddr;   // Write address
	logic        awvalid;  // Write address valid
	logic        awready;  // Write address ready
	logic [31:0] wdata;    // Write data
	logic        wvalid;   // Write data valid
	logic        wready;   // Write data ready
	logic [1:0]  bresp;    // Write response
	logic        bvalid;   // Write response valid
	logic        bready;   // Write response ready
	logic [23:0] araddr;   // Read address
	logic        arvalid;  // Read address valid
	logic        arready;  // Read address ready
	logic [31:0] rdata;    // Read data
	logic [1:0]  rresp;    // Read response
	logic        rvalid;   // Read data valid
	logic        rready;   // Read data ready
	logic [7:0]  tcp;      // Per-socket flags
	logic [7:0]  udp;
	logic [7:0]  mac;
	logic [7:0]  ppp;
	logic [7:0]  mc;
	logic [7:0]  nd;
	logic [7:0]  ig;
	logic [7:0]  lis_go;   // Start pulses
	logic [7:0]  con_go;
	logic [7:0]  seen_lis; // Sticky copies of the pulses
	logic [7:0]  seen_con;
	logic        clr;      // Clears the sticky copies
	int          fail_count;
	int          samples_checked;

	smm_top smm_top_inst (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sock_tcp_q(tcp), .sock_udp_q(udp), .sock_mac_raw_q(mac),
		.sock_pppoe_q(ppp), .sock_mcast_q(mc), .sock_no_dly_ack_q(nd), .sock_igmp_v1_q(ig),
		.listen_go_q(lis_go), .connect_go_q(con_go));

	// Free-running clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Pulses last one cycle, so latch them rather than poll
	always @(posedge clk) begin
		seen_lis <= (clr || rst) ? 8'h00 : (seen_lis | lis_go);
		seen_con <= (clr || rst) ? 8'h00 : (seen_con | con_go);
	end

	task automatic summarize();
		$display("Checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Bounded waits end the run instead of hanging
	task automatic tick(inout int n);
		@(posedge clk);
		n++;
		if (n > 100) begin
			fail_count++;
			$display("[FAIL] bus wait expected handshake seen none");
			summarize();
		end
	endtask

	function automatic logic [23:0] ad(input logic [2:0] s, input logic [7:0] off);
		return `SMM_SOCK_BASE | {13'h0000, s, off};
	endfunction

	// One write: address and data offered together, each dropped once taken
	task automatic wr(input logic [23:0] a, input logic [7:0] d, input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		int   n;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		n = 0;
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			tick(n);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) begin
			tick(n);
		end
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
		// Gap so a following call never reassigns bready in this time step
		@(posedge clk);
	endtask

	// One read, rready held until data arrive
	task automatic rd(input logic [23:0] a, input logic [7:0] ed, input logic [1:0] er);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do tick(n); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) begin
			tick(n);
		end
		rready <= 1'b0;
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		chk("rdata", {24'h000000, ed}, rdata);
		// Gap so a following call never reassigns rready in this time step
		@(posedge clk);
	endtask

	// Outputs trail the register by one cycle; pulses come with it, their sticky copies one later
	task automatic settle();
		repeat (2) @(posedge clk);
	endtask

	task automatic t_reset();
		rd(ad(3'd0, `SMM_OFF_MODE), `SMM_MODE_RST, `SMM_RESP_OKAY);
		rd(ad(3'd7, `SMM_OFF_MODE), `SMM_MODE_RST, `SMM_RESP_OKAY);
		chk("flags after reset", 32'h00000000, {tcp, udp, mac, ppp});
		chk("options after reset", 32'h00000000, {mc, nd, ig, lis_go});
	endtask

	// Every protocol code on socket zero and on socket one, then open
	task automatic t_proto();
		logic [3:0] e;
		logic [7:0] st;
		for (int s = 0; s < 2; s++) begin
			for (int c = 0; c < 6; c++) begin
				wr(ad(s[2:0], `SMM_OFF_MODE), c[7:0], `SMM_RESP_OKAY);
				settle();
				e = {c == 5 && s == 0, c == 4 && s == 0, c == 2, c == 1};
				chk("protocol flags", {28'h0, e}, {28'h0, ppp[s], mac[s], udp[s], tcp[s]});
				rd(ad(s[2:0], `SMM_OFF_MODE), c[7:0], `SMM_RESP_OKAY);
				case (c)
					1: st = `SMM_ST_INIT;
					2: st = `SMM_ST_UDP;
					3: st = `SMM_ST_IPRAW;
					4: st = (s == 0) ? `SMM_ST_MACRAW : `SMM_ST_CLOSED;
					5: st = (s == 0) ? `SMM_ST_PPPOE : `SMM_ST_CLOSED;
					default: st = `SMM_ST_CLOSED;
				endcase
				wr(ad(s[2:0], `SMM_OFF_CMD), `SMM_CMD_OPEN, `SMM_RESP_OKAY);
				rd(ad(s[2:0], `SMM_OFF_STAT), st, `SMM_RESP_OKAY);
				wr(ad(s[2:0], `SMM_OFF_CMD), `SMM_CMD_CLOSE, `SMM_RESP_OKAY);
			end
		end
	endtask

	// Option bits and reserved bits on socket two
	task automatic t_bits();
		logic [7:0] wv [5] = '{8'hff, 8'ha2, 8'h82, 8'ha1, 8'h22};
		logic [2:0] ev [5] = '{3'b000, 3'b101, 3'b100, 3'b010, 3'b000};
		for (int i = 0; i < 5; i++) begin
			wr(ad(3'd2, `SMM_OFF_MODE), wv[i], `SMM_RESP_OKAY);
			rd(ad(3'd2, `SMM_OFF_MODE), wv[i] & 8'haf, `SMM_RESP_OKAY);
			chk("mcast ack igmp", {29'h0, ev[i]}, {29'h0, mc[2], nd[2], ig[2]});
		end
	endtask

	// Listen and connect act only on an opened TCP socket
	task automatic t_cmd(input logic [2:0] s, input logic [7:0] m, input logic op, input logic [7:0] cmd,
		input logic [7:0] ep, input logic [7:0] st);
		clr <= 1'b1;
		wr(ad(s, `SMM_OFF_MODE), m, `SMM_RESP_OKAY);
		clr <= 1'b0;
		if (op) begin
			wr(ad(s, `SMM_OFF_CMD), `SMM_CMD_OPEN, `SMM_RESP_OKAY);
		end
		wr(ad(s, `SMM_OFF_CMD), cmd, `SMM_RESP_OKAY);
		settle();
		chk("start pulses", {24'h000000, ep}, {24'h000000, seen_lis | seen_con});
		rd(ad(s, `SMM_OFF_STAT), st, `SMM_RESP_OKAY);
	endtask

	initial begin
		rst = 1'b1;
		clr = 1'b0;
		awaddr = 24'h000000;
		awvalid = 1'b0;
		wdata = 32'h00000000;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 24'h000000;
		arvalid = 1'b0;
		rready = 1'b0;
		fail_count = 0;
		samples_checked = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_proto();
		// Multicast is set up but never opened: group address registers lie outside
		t_bits();
		t_cmd(3'd3, 8'h01, 1'b1, `SMM_CMD_LISTEN, 8'h08, `SMM_ST_LISTEN);
		t_cmd(3'd4, 8'h01, 1'b0, `SMM_CMD_CONNECT, 8'h00, `SMM_ST_CLOSED);
		t_cmd(3'd4, 8'h01, 1'b1, `SMM_CMD_CONNECT, 8'h10, `SMM_ST_SYNSENT);
		t_cmd(3'd5, 8'h02, 1'b1, `SMM_CMD_LISTEN, 8'h00, `SMM_ST_UDP);
		wr(ad(3'd0, 8'h0c), 8'h01, `SMM_RESP_SLVERR);
		rd(ad(3'd0, 8'h0c), 8'h00, `SMM_RESP_SLVERR);
		rd(24'h000000, 8'h00, `SMM_RESP_SLVERR);
		// Second reset mid-run must bring every socket back to closed
		rst <= 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		rd(ad(3'd3, `SMM_OFF_STAT), `SMM_ST_CLOSED, `SMM_RESP_OKAY);
		rd(ad(3'd2, `SMM_OFF_MODE), `SMM_MODE_RST, `SMM_RESP_OKAY);
		summarize();
	end
endmodule

// ### smm_top.sv
// Per-socket mode, command and status registers behind an AXI4-Lite slave.
// Assumes one clock, synchronous active-high reset, one write and one read in flight.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "smm_defines.svh"
module smm_top
	import smm_pkg::*;
(
	input  wire logic        clk,                 // System clock
	input  wire logic        rst,                 // Synchronous reset
	input  wire logic [23:0] s_axi_awaddr,        // Write address
	input  wire logic [2:0]  s_axi_awprot,        // Unused protection
	input  wire logic        s_axi_awvalid,       // Write address valid
	output logic             s_axi_awready,       // Write address ready
	input  wire logic [31:0] s_axi_wdata,         // Write data
	input  wire logic [3:0]  s_axi_wstrb,         // Byte enables
	input  wire logic        s_axi_wvalid,        // Write data valid
	output logic             s_axi_wready,        // Write data ready
	output logic [1:0]       s_axi_bresp,         // Write response
	output logic             s_axi_bvalid,        // Write response valid
	input  wire logic        s_axi_bready,        // Write response ready
	input  wire logic [23:0] s_axi_araddr,        // Read address
	input  wire logic [2:0]  s_axi_arprot,        // Unused protection
	input  wire logic        s_axi_arvalid,       // Read address valid
	output logic             s_axi_arready,       // Read address ready
	output logic [31:0]      s_axi_rdata,         // Read data
	output logic [1:0]       s_axi_rresp,         // Read response
	output logic             s_axi_rvalid,        // Read data valid
	input  wire logic        s_axi_rready,        // Read data ready
	output logic [7:0]       sock_tcp_q,          // Socket runs TCP
	output logic [7:0]       sock_udp_q,          // Socket runs UDP
	output logic [7:0]       sock_mac_raw_q,      // Socket runs MAC raw
	output logic [7:0]       sock_pppoe_q,        // Socket runs PPPoE
	output logic [7:0]       sock_mcast_q,        // Multicast in force
	output logic [7:0]       sock_no_dly_ack_q,   // Immediate ACK in force
	output logic [7:0]       sock_igmp_v1_q,      // IGMP v1 instead of v2
	output logic [7:0]       listen_go_q,         // Pulse: start listening
	output logic [7:0]       connect_go_q         // Pulse: start connecting
);
	import smm_pkg::*;

	localparam int NS = `SMM_NUM_SOCK;

	logic [7:0]  mode_q [NS];     // Mode registers
	logic [7:0]  mode_d [NS];
	logic [7:0]  stat_q [NS];     // Status registers
	logic [7:0]  stat_d [NS];
	logic        aw_full_q;       // Write address held
	logic        aw_full_d;
	logic [23:0] awaddr_q;        // Held write address
	logic [23:0] awaddr_d;
	logic        w_full_q;        // Write data held
	logic        w_full_d;
	logic [7:0]  wbyte_q;         // Held low data byte
	logic [7:0]  wbyte_d;
	logic        wlane_q;         // Held lane-0 enable
	logic        wlane_d;
	logic        awready_d;
	logic        wready_d;
	logic        bvalid_d;
	logic [1:0]  bresp_d;
	logic        arready_d;
	logic        rvalid_d;
	logic [1:0]  rresp_d;
	logic [31:0] rdata_d;
	logic [7:0]  listen_d;
	logic [7:0]  connect_d;
	logic        wr_fire;         // Write carried out this cycle
	smm_dec_t    wr_dec;          // Decoded held write address
	smm_dec_t    rd_dec;          // Decoded incoming read address

	// Per-socket meaning of the mode bytes
	logic [7:0]  dec_tcp, dec_udp, dec_mac, dec_ppp, dec_mc, dec_nda, dec_v1;
	logic [7:0]  open_stat [NS];

	assign wr_dec = smm_decode(awaddr_q);
	assign rd_dec = smm_decode(s_axi_araddr);

	// One decoder per socket; socket zero alone may use MAC raw and PPPoE
	for (genvar i = 0; i < NS; i++) begin : g_dec
		smm_mode_decode u_dec (
			.mode       (mode_q[i]),
			.sock_zero  (i == 0),
			.is_tcp     (dec_tcp[i]),
			.is_udp     (dec_udp[i]),
			.is_mac_raw (dec_mac[i]),
			.is_pppoe   (dec_ppp[i]),
			.mcast_on   (dec_mc[i]),
			.no_dly_ack (dec_nda[i]),
			.igmp_v1    (dec_v1[i]),
			.open_stat  (open_stat[i])
		);
	end

	// Write path: address and data in either order, then one response
	always_comb begin
		aw_full_d = aw_full_q;
		awaddr_d  = awaddr_q;
		w_full_d  = w_full_q;
		wbyte_d   = wbyte_q;
		wlane_d   = wlane_q;
		bvalid_d  = s_axi_bvalid;
		bresp_d   = s_axi_bresp;
		mode_d    = mode_q;
		stat_d    = stat_q;
		listen_d  = '0;
		connect_d = '0;
		wr_fire   = 1'b0;
		// Response taken
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		// Address channel
		if (s_axi_awvalid && s_axi_awready) begin
			aw_full_d = 1'b1;
			awaddr_d  = s_axi_awaddr;
		end
		// Data channel; only the low byte matters
		if (s_axi_wvalid && s_axi_wready) begin
			w_full_d = 1'b1;
			wbyte_d  = s_axi_wdata[7:0];
			wlane_d  = s_axi_wstrb[0];
		end
		// Both halves held: act and answer
		if (aw_full_q && w_full_q && !s_axi_bvalid) begin
			wr_fire   = 1'b1;
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			bresp_d   = wr_dec.hit ? `SMM_RESP_OKAY : `SMM_RESP_SLVERR;
			if (wr_dec.hit && wlane_q) begin
				unique case (wr_dec.kind)
					smm_reg_mode: begin
						// Reserved bits never stored
						mode_d[wr_dec.sock] = wbyte_q & `SMM_MODE_WMASK;
					end
					smm_reg_cmd: begin
						unique case (wbyte_q)
							`SMM_CMD_OPEN: begin
								stat_d[wr_dec.sock] = open_stat[wr_dec.sock];
							end
							`SMM_CMD_LISTEN: begin
								// Only a freshly opened TCP socket may listen
								if (dec_tcp[wr_dec.sock] && stat_q[wr_dec.sock] == `SMM_ST_INIT) begin
									stat_d[wr_dec.sock]   = `SMM_ST_LISTEN;
									listen_d[wr_dec.sock] = 1'b1;
								end
							end
							`SMM_CMD_CONNECT: begin
								if (dec_tcp[wr_dec.sock] && stat_q[wr_dec.sock] == `SMM_ST_INIT) begin
									stat_d[wr_dec.sock]    = `SMM_ST_SYNSENT;
									connect_d[wr_dec.sock] = 1'b1;
								end
							end
							`SMM_CMD_CLOSE: begin
								stat_d[wr_dec.sock] = `SMM_ST_CLOSED;
							end
							default: begin
								// Unknown commands are dropped
							end
						endcase
					end
					default: begin
						// Status is read-only; write answered but ignored
					end
				endcase
			end
		end
		// Ready from next state, so it comes straight from a flop
		awready_d = !aw_full_d && !bvalid_d;
		wready_d  = !w_full_d && !bvalid_d;
	end

	// Read path: one read at a time, data one cycle after the address
	always_comb begin
		rvalid_d = s_axi_rvalid;
		rresp_d  = s_axi_rresp;
		rdata_d  = s_axi_rdata;
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d  = rd_dec.hit ? `SMM_RESP_OKAY : `SMM_RESP_SLVERR;
			rdata_d  = '0;
			if (rd_dec.hit) begin
				unique case (rd_dec.kind)
					smm_reg_mode: rdata_d = {24'h000000, mode_q[rd_dec.sock]};
					smm_reg_stat: rdata_d = {24'h000000, stat_q[rd_dec.sock]};
					default:      rdata_d = '0; // Command reads as cleared
				endcase
			end
		end
		arready_d = !rvalid_d;
	end

	// Register everything; reset leaves every socket closed
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < NS; i++) begin
				mode_q[i] <= `SMM_MODE_RST;
				stat_q[i] <= `SMM_ST_CLOSED;
			end
			aw_full_q         <= 1'b0;
			awaddr_q          <= '0;
			w_full_q          <= 1'b0;
			wbyte_q           <= '0;
			wlane_q           <= 1'b0;
			s_axi_awready     <= 1'b0;
			s_axi_wready      <= 1'b0;
			s_axi_bvalid      <= 1'b0;
			s_axi_bresp       <= `SMM_RESP_OKAY;
			s_axi_arready     <= 1'b0;
			s_axi_rvalid      <= 1'b0;
			s_axi_rresp       <= `SMM_RESP_OKAY;
			s_axi_rdata       <= '0;
			sock_tcp_q        <= '0;
			sock_udp_q        <= '0;
			sock_mac_raw_q    <= '0;
			sock_pppoe_q      <= '0;
			sock_mcast_q      <= '0;
			sock_no_dly_ack_q <= '0;
			sock_igmp_v1_q    <= '0;
			listen_go_q       <= '0;
			connect_go_q      <= '0;
		end else begin
			mode_q            <= mode_d;
			stat_q            <= stat_d;
			aw_full_q         <= aw_full_d;
			awaddr_q          <= awaddr_d;
			w_full_q          <= w_full_d;
			wbyte_q           <= wbyte_d;
			wlane_q           <= wlane_d;
			s_axi_awready     <= awready_d;
			s_axi_wready      <= wready_d;
			s_axi_bvalid      <= bvalid_d;
			s_axi_bresp       <= bresp_d;
			s_axi_arready     <= arready_d;
			s_axi_rvalid      <= rvalid_d;
			s_axi_rresp       <= rresp_d;
			s_axi_rdata       <= rdata_d;
			sock_tcp_q        <= dec_tcp;
			sock_udp_q        <= dec_udp;
			sock_mac_raw_q    <= dec_mac;
			sock_pppoe_q      <= dec_ppp;
			sock_mcast_q      <= dec_mc;
			sock_no_dly_ack_q <= dec_nda;
			sock_igmp_v1_q    <= dec_v1;
			listen_go_q       <= listen_d;
			connect_go_q      <= connect_d;
		end
	end

	// Checks on socket behaviour
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_mode_store;
		wr_fire && wr_dec.hit && wlane_q && wr_dec.kind == smm_reg_mode
			|=> mode_q[$past(wr_dec.sock)] == ($past(wbyte_q) & `SMM_MODE_WMASK);
	endproperty
	a_mode_store: assert property (p_mode_store) else $error("mode write not stored");

	property p_tcp_flag;
		##1 sock_tcp_q[1] == ($past(mode_q[1][`SMM_PROTO_MSB:0]) == `SMM_PROTO_TCP);
	endproperty
	a_tcp_flag: assert property (p_tcp_flag) else $error("tcp flag wrong");

	property p_raw_sock0;
		sock_mac_raw_q[7:1] == '0 && sock_pppoe_q[7:1] == '0;
	endproperty
	a_raw_sock0: assert property (p_raw_sock0) else $error("raw mode on socket other than zero");

	property p_mcast;
		##1 sock_mcast_q[2] == ($past(mode_q[2][`SMM_BIT_MULTI])
			&& $past(mode_q[2][`SMM_PROTO_MSB:0]) == `SMM_PROTO_UDP);
	endproperty
	a_mcast: assert property (p_mcast) else $error("multicast outside udp");

	property p_nodly;
		sock_no_dly_ack_q[2] |-> $past(mode_q[2][`SMM_BIT_ACKSEL]) && sock_tcp_q[2];
	endproperty
	a_nodly: assert property (p_nodly) else $error("immediate ack outside tcp");

	property p_igmp;
		sock_igmp_v1_q[2] |-> sock_mcast_q[2] && $past(mode_q[2][`SMM_BIT_ACKSEL]);
	endproperty
	a_igmp: assert property (p_igmp) else $error("igmp v1 without multicast");

	property p_open;
		wr_fire && wr_dec.hit && wlane_q && wr_dec.kind == smm_reg_cmd && wbyte_q == `SMM_CMD_OPEN
			&& wr_dec.sock == 3'd0 && mode_q[0][`SMM_PROTO_MSB:0] == `SMM_PROTO_TCP
			|=> stat_q[0] == `SMM_ST_INIT;
	endproperty
	a_open: assert property (p_open) else $error("open on tcp did not reach init");

	property p_listen;
		listen_go_q[3] |-> $past(dec_tcp[3]) && $past(stat_q[3]) == `SMM_ST_INIT
			&& stat_q[3] == `SMM_ST_LISTEN;
	endproperty
	a_listen: assert property (p_listen) else $error("listen outside tcp init");

	property p_rsvd;
		(mode_q[3] & ~`SMM_MODE_WMASK) == 8'h00 && (mode_q[2] & ~`SMM_MODE_WMASK) == 8'h00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved mode bit set");

	c_open_udp: cover property (stat_q[1] == `SMM_ST_UDP);
	c_listen:   cover property (listen_go_q[3]);
	c_connect:  cover property (connect_go_q[4]);
	c_slverr:   cover property (s_axi_bvalid && s_axi_bresp == `SMM_RESP_SLVERR);
endmodule
